/* rtl/lro_exec.sv */
/*
  Execution slice for literal load, idle, the three returns and rotate left.
  Assumes the register file answers file_rdata_i in the same cycle as
  file_addr_i, and the stack hardware presents its top entry and pops on
  stack_pop_o. All inputs come from logic on ref_clk_i.
*/
// Summary of operation
// - Literal load puts literal in accumulator
// - Interrupt return pops stack top into PC
// - Interrupt return sets enable bit seven, two cycles
// - Subroutine return pops to PC, two cycles
// - Literal exit puts literal in accumulator
// - Literal exit loads PC from stack, two cycles
// - Rotate left through carry, one cycle
// - Destination one writes file, zero accumulator
`default_nettype none
module lro_exec #(
  parameter int DATA_W  = lro_pkg::DATA_W,
  parameter int PC_W    = lro_pkg::PC_W,
  parameter int FADDR_W = lro_pkg::FADDR_W
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 instr_valid_i,
  input  wire lro_pkg::lro_op_t     instr_op_i,
  input  wire logic [DATA_W-1:0]    literal_i,
  input  wire logic [FADDR_W-1:0]   file_addr_i,
  input  wire logic                 dest_sel_i,
  input  wire logic [PC_W-1:0]      stack_top_entry_i,
  input  wire logic [DATA_W-1:0]    file_rdata_i,
  input  wire logic [DATA_W-1:0]    irq_control_reg_i,
  output logic                      ready_o,
  output logic                      stack_pop_o,
  output logic [PC_W-1:0]           pc_o,
  output logic [DATA_W-1:0]         acc_o,
  output logic                      carry_o,
  output logic                      file_we_o,
  output logic [FADDR_W-1:0]        file_waddr_o,
  output logic [DATA_W-1:0]         file_wdata_o,
  output logic                      irq_control_we_o,
  output logic [DATA_W-1:0]         irq_control_wdata_o
);

  lro_pkg::lro_state_t state_reg;
  lro_pkg::lro_state_t state_next;
  logic [PC_W-1:0]     pc_reg;
  logic [PC_W-1:0]     pc_next;
  logic [DATA_W-1:0]   acc_reg;
  logic [DATA_W-1:0]   acc_next;
  logic                carry_reg;
  logic                carry_next;
  logic                file_we_reg;
  logic                file_we_next;
  logic [FADDR_W-1:0]  file_waddr_reg;
  logic [FADDR_W-1:0]  file_waddr_next;
  logic [DATA_W-1:0]   file_wdata_reg;
  logic [DATA_W-1:0]   file_wdata_next;
  logic                irq_we_reg;
  logic                irq_we_next;
  logic [DATA_W-1:0]   irq_wdata_reg;
  logic [DATA_W-1:0]   irq_wdata_next;
  logic                accept;
  logic [DATA_W-1:0]   rot_result;
  logic                rot_carry;

  // Returns take the stack top and need a second cycle
  function automatic logic takes_stack(input lro_pkg::lro_op_t op);
    takes_stack = (op == lro_pkg::INTERRUPT_RETURN_OP) ||
                  (op == lro_pkg::SUBROUTINE_RETURN_OP) ||
                  (op == lro_pkg::LITERAL_EXIT_OP);
  endfunction

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    pc_inc = pc + lro_pkg::PC_STEP;
  endfunction

  lro_rotate #(
    .DATA_W (DATA_W)
  ) i_lro_rotate (
    .data_i   (file_rdata_i),
    .carry_i  (carry_reg),
    .result_o (rot_result),
    .carry_o  (rot_carry)
  );

  assign ready_o     = (state_reg == lro_pkg::ST_EXEC);
  assign accept      = instr_valid_i && ready_o;
  assign stack_pop_o = accept && takes_stack(instr_op_i);

  always_comb begin
    state_next      = state_reg;
    pc_next         = pc_reg;
    acc_next        = acc_reg;
    carry_next      = carry_reg;
    file_we_next    = 1'h0;
    file_waddr_next = file_waddr_reg;
    file_wdata_next = file_wdata_reg;
    irq_we_next     = 1'h0;
    irq_wdata_next  = irq_wdata_reg;
    case (state_reg)
      lro_pkg::ST_EXEC: begin
        if (accept) begin
          if (takes_stack(instr_op_i)) begin
            pc_next    = stack_top_entry_i;
            state_next = lro_pkg::ST_FLUSH;
          end else begin
            pc_next = pc_inc(pc_reg);
          end
          case (instr_op_i)
            lro_pkg::LITERAL_LOAD_OP: begin
              acc_next = literal_i;
            end
            lro_pkg::INTERRUPT_RETURN_OP: begin
              irq_we_next    = 1'h1;
              irq_wdata_next = irq_control_reg_i | lro_pkg::IRQ_EN_MASK;
            end
            lro_pkg::LITERAL_EXIT_OP: begin
              acc_next = literal_i;
            end
            lro_pkg::ROTATE_LEFT_CARRY_OP: begin
              carry_next = rot_carry;
              if (dest_sel_i == lro_pkg::DEST_FILE) begin
                file_we_next    = 1'h1;
                file_waddr_next = file_addr_i;
                file_wdata_next = rot_result;
              end else begin
                acc_next = rot_result;
              end
            end
            default: begin
            end
          endcase
        end
      end
      lro_pkg::ST_FLUSH: begin
        state_next = lro_pkg::ST_EXEC;
      end
      default: begin
        state_next = lro_pkg::ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg      <= lro_pkg::ST_EXEC;
      pc_reg         <= lro_pkg::PC_RST;
      acc_reg        <= lro_pkg::ACC_RST;
      carry_reg      <= lro_pkg::CARRY_RST;
      file_we_reg    <= 1'h0;
      file_waddr_reg <= lro_pkg::FADDR_RST;
      file_wdata_reg <= lro_pkg::ACC_RST;
      irq_we_reg     <= 1'h0;
      irq_wdata_reg  <= lro_pkg::ACC_RST;
    end else begin
      state_reg      <= state_next;
      pc_reg         <= pc_next;
      acc_reg        <= acc_next;
      carry_reg      <= carry_next;
      file_we_reg    <= file_we_next;
      file_waddr_reg <= file_waddr_next;
      file_wdata_reg <= file_wdata_next;
      irq_we_reg     <= irq_we_next;
      irq_wdata_reg  <= irq_wdata_next;
    end
  end

  assign pc_o                = pc_reg;
  assign acc_o               = acc_reg;
  assign carry_o             = carry_reg;
  assign file_we_o           = file_we_reg;
  assign file_waddr_o        = file_waddr_reg;
  assign file_wdata_o        = file_wdata_reg;
  assign irq_control_we_o    = irq_we_reg;
  assign irq_control_wdata_o = irq_wdata_reg;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  lit_load_a: assert property (accept && instr_op_i == lro_pkg::LITERAL_LOAD_OP |=>
    acc_o == $past(literal_i) && $stable(carry_o) && ready_o && !file_we_o)
    else $error("literal load result wrong");

  irq_ret_pc_a: assert property (accept && instr_op_i == lro_pkg::INTERRUPT_RETURN_OP |->
    stack_pop_o ##1 pc_o == $past(stack_top_entry_i) && $stable(carry_o) && $stable(acc_o))
    else $error("interrupt return pc wrong");

  irq_ret_en_a: assert property (accept && instr_op_i == lro_pkg::INTERRUPT_RETURN_OP |=>
    irq_control_we_o && irq_control_wdata_o[lro_pkg::IRQ_EN_BIT] && !ready_o ##1 ready_o && !irq_control_we_o)
    else $error("interrupt return enable or timing wrong");

  sub_ret_a: assert property (accept && instr_op_i == lro_pkg::SUBROUTINE_RETURN_OP |=>
    pc_o == $past(stack_top_entry_i) && !irq_control_we_o && $stable(carry_o) && !ready_o ##1 ready_o)
    else $error("subroutine return wrong");

  lit_exit_acc_a: assert property (accept && instr_op_i == lro_pkg::LITERAL_EXIT_OP |=>
    acc_o == $past(literal_i) && $stable(carry_o))
    else $error("literal exit accumulator wrong");

  lit_exit_pc_a: assert property (accept && instr_op_i == lro_pkg::LITERAL_EXIT_OP |->
    stack_pop_o ##1 pc_o == $past(stack_top_entry_i) && !ready_o ##1 ready_o)
    else $error("literal exit pc or timing wrong");

  rot_carry_a: assert property (accept && instr_op_i == lro_pkg::ROTATE_LEFT_CARRY_OP |=>
    carry_o == $past(file_rdata_i[lro_pkg::MSB_BIT]) && ready_o && pc_o == pc_inc($past(pc_o)))
    else $error("rotate carry wrong");

  rot_file_a: assert property (accept && instr_op_i == lro_pkg::ROTATE_LEFT_CARRY_OP && dest_sel_i |=>
    file_we_o && file_waddr_o == $past(file_addr_i) && $stable(acc_o) &&
    file_wdata_o == {$past(file_rdata_i[DATA_W-2:0]), $past(carry_o)})
    else $error("rotate to file wrong");

  rot_acc_a: assert property (accept && instr_op_i == lro_pkg::ROTATE_LEFT_CARRY_OP && !dest_sel_i |=>
    !file_we_o && acc_o == {$past(file_rdata_i[DATA_W-2:0]), $past(carry_o)})
    else $error("rotate to accumulator wrong");

  idle_step_a: assert property (accept && instr_op_i == lro_pkg::IDLE_INSTRUCTION |=>
    pc_o == pc_inc($past(pc_o)) && $stable(acc_o) && $stable(carry_o) && !file_we_o && !irq_control_we_o && ready_o)
    else $error("idle instruction changed state");

  irq_ret_c: cover property (accept && instr_op_i == lro_pkg::INTERRUPT_RETURN_OP ##2 accept);
  lit_exit_c: cover property (accept && instr_op_i == lro_pkg::LITERAL_EXIT_OP);
  rot_acc_c: cover property (accept && instr_op_i == lro_pkg::ROTATE_LEFT_CARRY_OP && !dest_sel_i);
  back_to_back_c: cover property (accept ##1 accept ##1 accept);

endmodule // lro_exec
`default_nettype wire

/* rtl/lro_pkg.sv */
/*
  Shared constants and types of the literal, return and rotate execution slice.
  Assumes a core that decodes instructions into lro_op_t before this slice.
*/
`default_nettype none
package lro_pkg;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;

  localparam int IRQ_EN_BIT = 7;
  localparam int MSB_BIT = 7;

  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_EN_MASK = 8'h80;
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
  localparam logic [PC_W-1:0]   PC_STEP  = 13'h0001;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
  localparam logic              CARRY_RST = 1'h0;
  localparam logic              DEST_FILE = 1'h1;

  typedef enum logic [2:0] {
    IDLE_INSTRUCTION     = 3'h0,
    LITERAL_LOAD_OP      = 3'h1,
    INTERRUPT_RETURN_OP  = 3'h2,
    SUBROUTINE_RETURN_OP = 3'h3,
    LITERAL_EXIT_OP      = 3'h4,
    ROTATE_LEFT_CARRY_OP = 3'h5
  } lro_op_t;

  typedef enum logic {
    ST_EXEC  = 1'h0,
    ST_FLUSH = 1'h1
  } lro_state_t;
endpackage : lro_pkg
`default_nettype wire

/* rtl/lro_rotate.sv */
/*
  Combinational rotate left through carry.
  Assumes operand and carry are stable within the cycle that uses them.
*/
`default_nettype none
module lro_rotate #(
  parameter int DATA_W = lro_pkg::DATA_W
) (
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              carry_i,
  output logic      [DATA_W-1:0] result_o,
  output logic                   carry_o
);
  // Old carry enters at the bottom, old top bit leaves as carry
  assign result_o = {data_i[DATA_W-2:0], carry_i};
  assign carry_o  = data_i[DATA_W-1];
endmodule // lro_rotate
`default_nettype wire

/* tb/tb_literal_return_rotate_ops.sv */
/*
  Self-checking bench of lro_exec: literal load, idle, the three returns, rotate.
  Assumes the bench itself plays return stack, register file and irq_control_reg.
*/
`default_nettype none
module tb_literal_return_rotate_ops;
  timeunit 1ns;
  timeprecision 100ps;

  logic             ref_clk_i;
  logic             rst_n_i;
  logic             instr_valid_i;
  lro_pkg::lro_op_t instr_op_i;
  logic [7:0]       literal_i;
  logic [6:0]       file_addr_i;
  logic             dest_sel_i;
  logic [12:0]      stack_top_entry_i;
  logic [7:0]       file_rdata_i;
  logic [7:0]       irq_control_reg_i;
  logic             ready_o;
  logic             stack_pop_o;
  logic [12:0]      pc_o;
  logic [7:0]       acc_o;
  logic             carry_o;
  logic             file_we_o;
  logic [6:0]       file_waddr_o;
  logic [7:0]       file_wdata_o;
  logic             irq_control_we_o;
  logic [7:0]       irq_control_wdata_o;
  int               n_fail;
  int               cmp_count;
  logic [12:0]      exp_pc;
  logic [7:0]       exp_acc;
  logic             exp_c;

  lro_exec i_lro_exec (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
    .literal_i(literal_i), .file_addr_i(file_addr_i), .dest_sel_i(dest_sel_i),
    .stack_top_entry_i(stack_top_entry_i), .file_rdata_i(file_rdata_i), .irq_control_reg_i(irq_control_reg_i),
    .ready_o(ready_o), .stack_pop_o(stack_pop_o), .pc_o(pc_o), .acc_o(acc_o), .carry_o(carry_o),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .irq_control_we_o(irq_control_we_o), .irq_control_wdata_o(irq_control_wdata_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_state();
    chk(16'(pc_o), 16'(exp_pc));
    chk(16'(acc_o), 16'(exp_acc));
    chk(16'(carry_o), 16'(exp_c));
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Offer one instruction, let the accepting edge pass, return settled
  task automatic step(input lro_pkg::lro_op_t op, input logic [7:0] k, input logic [6:0] a,
                      input logic d, input logic [12:0] t, input logic [7:0] rd);
    logic pop;
    pop = op inside {lro_pkg::INTERRUPT_RETURN_OP, lro_pkg::SUBROUTINE_RETURN_OP, lro_pkg::LITERAL_EXIT_OP};
    instr_op_i = op;
    literal_i = k;
    file_addr_i = a;
    dest_sel_i = d;
    stack_top_entry_i = t;
    file_rdata_i = rd;
    instr_valid_i = 1'b1;
    #2;
    chk(16'(stack_pop_o), 16'(pop));
    @(posedge ref_clk_i);
    #1;
  endtask

  // Common return checks, then the same return offered in the busy cycle must be ignored
  task automatic ret_cycle(input lro_pkg::lro_op_t op, input logic [7:0] k, input logic [12:0] t);
    step(op, k, 7'h00, 1'b0, t, 8'h00);
    exp_pc = t;
    chk_state();
    chk(16'(ready_o), 16'h0000);
    chk(16'(irq_control_we_o), 16'(op == lro_pkg::INTERRUPT_RETURN_OP));
    instr_op_i = op;
    literal_i = 8'hAA;
    stack_top_entry_i = 13'h0000;
    #1;
    chk(16'(stack_pop_o), 16'h0000);
    @(posedge ref_clk_i);
    #1;
    chk_state();
    chk(16'(ready_o), 16'h0001);
    chk(16'(irq_control_we_o), 16'h0000);
  endtask

  task automatic t_reset();
    exp_pc = 13'h0000;
    exp_acc = 8'h00;
    exp_c = 1'b0;
    chk_state();
    chk(16'({ready_o, file_we_o, irq_control_we_o}), 16'h0004);
    $display("test reset done");
  endtask

  task automatic t_literal();
    logic [7:0] vals [3];
    vals = '{8'hFF, 8'h00, 8'h5A};
    foreach (vals[i]) begin
      step(lro_pkg::LITERAL_LOAD_OP, vals[i], 7'h00, 1'b0, 13'h0000, 8'h00);
      exp_acc = vals[i];
      exp_pc++;
      chk_state();
      chk(16'(ready_o), 16'h0001);
    end
    $display("test literal done");
  endtask

  task automatic t_idle();
    step(lro_pkg::IDLE_INSTRUCTION, 8'h33, 7'h12, 1'b1, 13'h1234, 8'hFF);
    exp_pc++;
    chk_state();
    chk(16'({file_we_o, irq_control_we_o}), 16'h0000);
    $display("test idle done");
  endtask

  task automatic t_rotate();
    step(lro_pkg::ROTATE_LEFT_CARRY_OP, 8'h00, 7'h7F, 1'b0, 13'h0000, 8'hE6);
    exp_pc++;
    exp_acc = 8'hCC;
    exp_c = 1'b1;
    chk_state();
    chk(16'(file_we_o), 16'h0000);
    step(lro_pkg::ROTATE_LEFT_CARRY_OP, 8'h00, 7'h7F, 1'b1, 13'h0000, 8'h01);
    exp_pc++;
    exp_c = 1'b0;
    chk_state();
    chk(16'({file_we_o, file_waddr_o, file_wdata_o}), 16'hFF03);
    step(lro_pkg::IDLE_INSTRUCTION, 8'h00, 7'h00, 1'b0, 13'h0000, 8'h00);
    exp_pc++;
    chk(16'(file_we_o), 16'h0000);
    $display("test rotate done");
  endtask

  task automatic t_iret();
    irq_control_reg_i = 8'h15;
    ret_cycle(lro_pkg::INTERRUPT_RETURN_OP, 8'h77, 13'h1FFF);
    chk(16'(irq_control_wdata_o), 16'h0095);
    $display("test interrupt return done");
  endtask

  task automatic t_sret();
    ret_cycle(lro_pkg::SUBROUTINE_RETURN_OP, 8'h77, 13'h0421);
    $display("test subroutine return done");
  endtask

  task automatic t_lexit();
    exp_acc = 8'h3C;
    ret_cycle(lro_pkg::LITERAL_EXIT_OP, 8'h3C, 13'h0ABC);
    $display("test literal exit done");
  endtask

  // Reset in mid-run must clear state at once, then allow work again
  task automatic t_midreset();
    instr_valid_i = 1'b0;
    rst_n_i = 1'b0;
    #1;
    exp_pc = 13'h0000;
    exp_acc = 8'h00;
    exp_c = 1'b0;
    chk_state();
    chk(16'({ready_o, stack_pop_o, file_we_o, irq_control_we_o}), 16'h0008);
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    step(lro_pkg::LITERAL_LOAD_OP, 8'h81, 7'h00, 1'b0, 13'h0000, 8'h00);
    exp_acc = 8'h81;
    exp_pc++;
    chk_state();
    $display("test mid-run reset done");
  endtask

  initial begin
    #(300 * 25);
    n_fail++;
    final_report();
  end

  initial begin
    n_fail = 0;
    cmp_count = 0;
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_op_i = lro_pkg::IDLE_INSTRUCTION;
    literal_i = 8'h00;
    file_addr_i = 7'h00;
    dest_sel_i = 1'b0;
    stack_top_entry_i = 13'h0000;
    file_rdata_i = 8'h00;
    irq_control_reg_i = 8'h00;
    repeat (5) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_literal();
    t_idle();
    t_rotate();
    t_iret();
    t_sret();
    t_lexit();
    t_midreset();
    final_report();
  end
endmodule // tb_literal_return_rotate_ops
`default_nettype wire
